/* design/cmc_mode_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - request field selects mode; status reports it
// - mode change waits for pending transmissions; code leaves sleep without waiting
// - top request bit asks configuration; writes follow; code enters it on request 100 only
// - request zero brings module online normal
// - configuration registers locked outside configuration
// - configuration entry waits for frame end
// - configuration: silent, counters cleared, pins released
// - code 001 sleeps and stops clock
// - sleep accepted when no frame is active, or mid-frame after eleven recessive bits
// - sleep: silent, counters kept, transmit recessive
// - wake flag on recessive-to-dominant edge only
// - wake returns previous mode, frame dropped
// - only normal mode transmits, acks, flags errors
// - listen-only receives filtered frames, drives nothing
// - loopback routes internally, releases transmit pin
// - filters still gate silent modes
// - receive mode 11 keeps errored frames in legacy mode only
// - legacy functional mode after every reset
// - enhanced mode: sixteen filters, extra buffers
// - data byte filter length 0 to 18
// - fifo depth set by first transmit buffer
module cmc_mode_ctrl
  import cmc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // protocol engine status
  input wire logic tx_pending_i,
  input wire logic frame_active_i,
  input wire logic bit_tick_i,
  // bus pin
  input wire logic can_rx_i,
  // controls to the protocol engine
  output logic tx_allow_o,
  output logic rx_allow_o,
  output logic ack_err_drive_o,
  output logic loopback_o,
  output logic err_cnt_clear_o,
  output logic err_cnt_hold_o,
  output logic can_transmit_pin_recessive_o,
  output logic can_transmit_pin_port_io_o,
  output logic clk_gate_off_o,
  output logic drop_frame_o,
  output logic keep_errored_o,
  output logic filter_gate_o,
  output logic [1:0] func_mode_o,
  output logic [3:0] fifo_depth_o,
  output logic [4:0] data_byte_filter_length_o,
  output logic wake_irq_o
);

  logic rx_meta_r;
  logic rx_sync_r;
  logic rx_prev_r;
  logic [2:0] mode_request_field_r;
  logic [2:0] mode_status_field_r;
  logic [2:0] mode_status_field_nxt;
  logic [2:0] prev_mode_r;
  cmc_state_t state_r;
  cmc_state_t state_nxt;
  logic [3:0] idle_cnt_r;
  logic bus_idle;
  logic wake_flag_r;
  logic wake_interrupt_enable_r;
  logic wake_disable_r;
  logic [7:0] cfg_r;
  logic [1:0] func_r;
  logic [1:0] receive_mode_field_r;
  logic [CMC_NUM_PBUF-1:0] bsel_r;
  logic [4:0] sdfl_r;
  logic [3:0] depth;
  logic [3:0] depth_at [CMC_NUM_PBUF+1];
  logic in_cfg;
  logic in_sleep;
  logic change_ok;
  logic sleep_ok;
  logic dom_edge;
  logic [7:0] rdata;

  function automatic logic is_mode(input logic [2:0] m,
                                   input logic [2:0] code);
    is_mode = (m == code);
  endfunction : is_mode

  function automatic logic wr_hit(input logic wr,
                                  input logic [3:0] addr,
                                  input logic [3:0] target);
    wr_hit = wr && (addr == target);
  endfunction : wr_hit

  // reset to recessive so leaving reset shows no false wake edge
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= can_rx_i;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  assign dom_edge = rx_prev_r & ~rx_sync_r;
  assign in_cfg = is_mode(mode_status_field_r, CMC_MODE_CONFIG);
  assign in_sleep = (state_r == CMC_ST_SLEEP);

  // recessive bit counter for idle detection
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      idle_cnt_r <= '0;
    end else if (!rx_sync_r) begin
      idle_cnt_r <= '0;
    end else if (bit_tick_i && idle_cnt_r < 4'(CMC_IDLE_BITS)) begin
      idle_cnt_r <= idle_cnt_r + 4'h1;
    end
  end

  assign bus_idle = (idle_cnt_r == 4'(CMC_IDLE_BITS));

  // pending transmissions drain first; a frame on the wire holds it too
  assign change_ok = !tx_pending_i && !frame_active_i;
  // sleep may also slip in once the bus has gone idle mid-frame
  assign sleep_ok = !tx_pending_i && (!frame_active_i || bus_idle);

  // request register; wake forces it back to the pre-sleep mode
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      mode_request_field_r <= CMC_MODE_RST;
    end else if (in_sleep && dom_edge) begin
      mode_request_field_r <= prev_mode_r;
    end else if (wr_hit(reg_wr_i, reg_addr_i, CMC_CTRL_ADDR)) begin
      mode_request_field_r <= reg_wdata_i[CMC_REQ_LSB+:3];
    end
  end

  always_comb begin
    state_nxt = state_r;
    mode_status_field_nxt = mode_status_field_r;
    unique case (state_r)
      CMC_ST_RUN: begin
        if (mode_request_field_r != mode_status_field_r) begin
          state_nxt = CMC_ST_WAIT;
        end
      end
      CMC_ST_WAIT: begin
        if (mode_request_field_r == mode_status_field_r) begin
          state_nxt = CMC_ST_RUN;
        end else if (is_mode(mode_request_field_r, CMC_MODE_SLEEP)) begin
          if (sleep_ok) begin
            state_nxt = CMC_ST_SLEEP;
            mode_status_field_nxt = CMC_MODE_SLEEP;
          end
        end else if (change_ok) begin
          state_nxt = CMC_ST_RUN;
          mode_status_field_nxt = mode_request_field_r;
        end
      end
      // nothing is on the wire in sleep, so leaving it needs no wait
      CMC_ST_SLEEP: begin
        if (!is_mode(mode_request_field_r, CMC_MODE_SLEEP)) begin
          state_nxt = CMC_ST_RUN;
          mode_status_field_nxt = mode_request_field_r;
        end
      end
      default: state_nxt = CMC_ST_RUN;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_r <= CMC_ST_RUN;
      mode_status_field_r <= CMC_MODE_RST;
      prev_mode_r <= CMC_MODE_NORMAL;
    end else begin
      state_r <= state_nxt;
      mode_status_field_r <= mode_status_field_nxt;
      if (state_nxt == CMC_ST_SLEEP && state_r != CMC_ST_SLEEP) begin
        prev_mode_r <= mode_status_field_r;
      end
    end
  end

  // wake flag: hardware set beats software clear
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      wake_flag_r <= 1'b0;
      wake_interrupt_enable_r <= 1'b0;
      wake_disable_r <= 1'b0;
    end else begin
      if (in_sleep && dom_edge && !wake_disable_r) begin
        wake_flag_r <= 1'b1;
      end else if (wr_hit(reg_wr_i, reg_addr_i, CMC_WAKE_ADDR)) begin
        wake_flag_r <= reg_wdata_i[0];
      end
      if (wr_hit(reg_wr_i, reg_addr_i, CMC_WAKE_ADDR)) begin
        wake_interrupt_enable_r <= reg_wdata_i[1];
        wake_disable_r <= reg_wdata_i[2];
      end
    end
  end

  // locked configuration registers
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cfg_r <= CMC_CFG_RST;
      func_r <= CMC_FUNC_LEGACY;
      bsel_r <= '0;
      sdfl_r <= '0;
    end else if (reg_wr_i && in_cfg) begin
      unique case (reg_addr_i)
        CMC_CFG_ADDR: cfg_r <= reg_wdata_i;
        CMC_FUNC_ADDR: begin
          if (reg_wdata_i[1:0] != 2'h3) begin
            func_r <= reg_wdata_i[1:0];
          end
          if (reg_wdata_i[6:2] <= CMC_SDFL_MAX) begin
            sdfl_r <= reg_wdata_i[6:2];
          end
        end
        CMC_BSEL_ADDR: bsel_r <= reg_wdata_i[CMC_NUM_PBUF-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      receive_mode_field_r <= '0;
    end else if (wr_hit(reg_wr_i, reg_addr_i, CMC_RXB_ADDR)) begin
      receive_mode_field_r <= reg_wdata_i[1:0];
    end
  end

  // fifo ends at the first transmit-configured buffer; the chain runs
  // from the top buffer down so the lowest transmit buffer wins
  assign depth_at[CMC_NUM_PBUF] = 4'(CMC_FIFO_MAX);
  for (genvar g = 0; g < CMC_NUM_PBUF; g++) begin : g_fifo_end
    assign depth_at[g] = bsel_r[g] ? 4'(CMC_FIFO_MIN + g)
                                   : depth_at[g + 1];
  end
  assign depth = depth_at[0];

  // unmapped words read as zero
  always_comb begin
    unique case (reg_addr_i)
      CMC_CTRL_ADDR: rdata = {mode_request_field_r, 5'h00};
      CMC_STAT_ADDR: rdata = {mode_status_field_r, 5'h00};
      CMC_FUNC_ADDR: rdata = {1'b0, sdfl_r, func_r};
      CMC_CFG_ADDR: rdata = cfg_r;
      CMC_WAKE_ADDR: rdata = {5'h00, wake_disable_r,
                              wake_interrupt_enable_r, wake_flag_r};
      CMC_RXB_ADDR: rdata = {6'h00, receive_mode_field_r};
      CMC_BSEL_ADDR: rdata = {2'b00, bsel_r};
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata : 8'h00;
    end
  end

  // bus drive controls, all registered
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      tx_allow_o <= 1'b0;
      ack_err_drive_o <= 1'b0;
      loopback_o <= 1'b0;
      can_transmit_pin_recessive_o <= 1'b1;
      can_transmit_pin_port_io_o <= 1'b1;
    end else begin
      tx_allow_o <= is_mode(mode_status_field_r, CMC_MODE_NORMAL);
      ack_err_drive_o <= is_mode(mode_status_field_r, CMC_MODE_NORMAL);
      loopback_o <= is_mode(mode_status_field_r, CMC_MODE_LOOP);
      can_transmit_pin_recessive_o <= !is_mode(mode_status_field_r,
                                              CMC_MODE_NORMAL);
      can_transmit_pin_port_io_o <= in_cfg ||
        is_mode(mode_status_field_r, CMC_MODE_LOOP);
    end
  end

  // receive path, error counters and clock gate
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rx_allow_o <= 1'b0;
      err_cnt_clear_o <= 1'b1;
      err_cnt_hold_o <= 1'b0;
      clk_gate_off_o <= 1'b0;
      drop_frame_o <= 1'b0;
    end else begin
      rx_allow_o <= !in_cfg && !in_sleep;
      err_cnt_clear_o <= in_cfg ||
        is_mode(mode_status_field_r, CMC_MODE_LISTEN);
      err_cnt_hold_o <= in_sleep;
      clk_gate_off_o <= in_sleep;
      drop_frame_o <= in_sleep && dom_edge;
    end
  end

  // functional mode and receive filtering
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      keep_errored_o <= 1'b0;
      filter_gate_o <= 1'b1;
      func_mode_o <= CMC_FUNC_LEGACY;
      fifo_depth_o <= 4'(CMC_FIFO_MAX);
      data_byte_filter_length_o <= '0;
    end else begin
      keep_errored_o <= func_r == CMC_FUNC_LEGACY &&
        receive_mode_field_r == CMC_RXM_ERR;
      filter_gate_o <= 1'b1;
      func_mode_o <= func_r;
      fifo_depth_o <= depth;
      data_byte_filter_length_o <= sdfl_r;
    end
  end

  // wake interrupt
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      wake_irq_o <= 1'b0;
    end else begin
      wake_irq_o <= wake_flag_r && wake_interrupt_enable_r &&
        !wake_disable_r;
    end
  end

endmodule : cmc_mode_ctrl

/* design/cmc_pkg.sv */
package cmc_pkg;

  // register word offsets
  localparam logic [3:0] CMC_CTRL_ADDR = 4'h0;
  localparam logic [3:0] CMC_STAT_ADDR = 4'h1;
  localparam logic [3:0] CMC_FUNC_ADDR = 4'h2;
  localparam logic [3:0] CMC_CFG_ADDR = 4'h3;
  localparam logic [3:0] CMC_WAKE_ADDR = 4'h4;
  localparam logic [3:0] CMC_RXB_ADDR = 4'h5;
  localparam logic [3:0] CMC_BSEL_ADDR = 4'h6;

  // field positions
  localparam int CMC_REQ_LSB = 5;
  localparam int CMC_SDFL_W = 5;

  // mode encodings
  localparam logic [2:0] CMC_MODE_NORMAL = 3'h0;
  localparam logic [2:0] CMC_MODE_SLEEP = 3'h1;
  localparam logic [2:0] CMC_MODE_LOOP = 3'h2;
  localparam logic [2:0] CMC_MODE_LISTEN = 3'h3;
  localparam logic [2:0] CMC_MODE_CONFIG = 3'h4;

  // functional modes
  localparam logic [1:0] CMC_FUNC_LEGACY = 2'h0;
  localparam logic [1:0] CMC_FUNC_ENH = 2'h1;
  localparam logic [1:0] CMC_FUNC_FIFO = 2'h2;

  // reset values, limits and codes
  localparam logic [2:0] CMC_MODE_RST = 3'h4;
  localparam logic [7:0] CMC_CFG_RST = 8'h00;
  localparam logic [4:0] CMC_SDFL_MAX = 5'h12;
  localparam logic [1:0] CMC_RXM_ERR = 2'h3;

  // timing and sizing counts
  localparam int CMC_IDLE_BITS = 11;
  localparam int CMC_FIFO_MIN = 2;
  localparam int CMC_FIFO_MAX = 8;
  localparam int CMC_NUM_PBUF = 6;

  typedef enum logic [1:0] {
    CMC_ST_RUN,
    CMC_ST_WAIT,
    CMC_ST_SLEEP
  } cmc_state_t;

endpackage : cmc_pkg

/* verification/cmc_bus_model.sv */
`timescale 1ns/1ps
module cmc_bus_model (
  // bench control
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [7:0] bits_i,
  // bus side
  output logic can_rx_o,
  output logic frame_active_o,
  output logic bit_tick_o
);
  int div_r = 0;
  int left_r = 0;
  initial begin
    can_rx_o = 1'b1;
    frame_active_o = 1'b0;
    bit_tick_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    div_r <= (div_r == 3) ? 0 : div_r + 1;
    bit_tick_o <= (div_r == 3);
    if (go_i) begin
      left_r <= bits_i + 12;
      frame_active_o <= 1'b1;
      can_rx_o <= 1'b0;
    end else if (bit_tick_o && left_r > 0) begin
      left_r <= left_r - 1;
      frame_active_o <= left_r > 1;
      // dominant every fifth body bit, as stuffing would; pull-up after
      can_rx_o <= (left_r <= 12) | (left_r % 5 != 0 && 1'($urandom));
    end
  end
endmodule : cmc_bus_model

/* verification/cmc_mode_ctrl_assertions.sv */
`timescale 1ns/1ps
module cmc_mode_ctrl_assertions
  import cmc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // inputs watched
  input wire logic reg_rd_i,
  input wire logic tx_pending_i,
  // outputs watched
  input wire logic [7:0] reg_rdata_o,
  input wire logic tx_allow_o,
  input wire logic rx_allow_o,
  input wire logic ack_err_drive_o,
  input wire logic loopback_o,
  input wire logic err_cnt_clear_o,
  input wire logic err_cnt_hold_o,
  input wire logic can_transmit_pin_recessive_o,
  input wire logic can_transmit_pin_port_io_o,
  input wire logic clk_gate_off_o,
  input wire logic drop_frame_o,
  input wire logic filter_gate_o,
  input wire logic [1:0] func_mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // three samples rule out a change that began before the pending flag
  sequence s_tx_busy;
    tx_pending_i [*3];
  endsequence
  a_tx_normal: assert property (
    tx_allow_o |-> ack_err_drive_o && !can_transmit_pin_recessive_o)
    else $error("transmit outside normal");
  a_sleep_quiet: assert property (
    clk_gate_off_o |-> can_transmit_pin_recessive_o && err_cnt_hold_o
      && !rx_allow_o) else $error("sleep not quiet");
  a_loop_pin: assert property (
    loopback_o |-> can_transmit_pin_port_io_o && !ack_err_drive_o)
    else $error("loopback drives bus");
  a_listen_quiet: assert property (
    rx_allow_o && err_cnt_clear_o |-> !ack_err_drive_o && !loopback_o)
    else $error("listen drives bus");
  a_filter_on: assert property (filter_gate_o)
    else $error("filters bypassed");
  a_drop_pulse: assert property (
    drop_frame_o |=> !drop_frame_o ##[0:1] !clk_gate_off_o)
    else $error("bad wake drop");
  a_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("stray rdata");
  a_defer_busy: assert property (
    s_tx_busy |-> !$rose(clk_gate_off_o) && !$rose(tx_allow_o))
    else $error("mode changed while pending");
  a_legacy_reset: assert property (
    $rose(resetn_i) |-> func_mode_o == CMC_FUNC_LEGACY)
    else $error("not legacy after reset");
endmodule : cmc_mode_ctrl_assertions
bind cmc_mode_ctrl cmc_mode_ctrl_assertions cmc_chk_inst (.*);

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench
  import cmc_pkg::*;
;
  logic mclk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic tx_pending_i = 0, go = 0;
  logic [3:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, got;
  logic [7:0] reg_rdata_o;
  logic frame_active_i, bit_tick_i, can_rx_i, ack_err_drive_o, drop_frame_o;
  logic tx_allow_o, rx_allow_o, loopback_o, err_cnt_clear_o, err_cnt_hold_o;
  logic can_transmit_pin_recessive_o, can_transmit_pin_port_io_o;
  logic clk_gate_off_o, keep_errored_o, filter_gate_o, wake_irq_o;
  logic [1:0] func_mode_o;
  logic [3:0] fifo_depth_o;
  logic [4:0] data_byte_filter_length_o;
  int miscompares = 0, checks_done = 0, cyc = 0, drops = 0, sdfl, k;
  int seq_q[$] = '{0, 2, 3, 4, 0, 1};
  logic [7:0] exp_out [5] = '{8'hC0, 8'h13, 8'h66, 8'h4A, 8'h0E};
  wire [7:0] outv = {tx_allow_o, rx_allow_o, loopback_o, clk_gate_off_o,
    err_cnt_clear_o, can_transmit_pin_port_io_o,
    can_transmit_pin_recessive_o, err_cnt_hold_o};
  cmc_mode_ctrl cmc_mode_ctrl_inst (.*);
  cmc_bus_model cmc_bus_model_inst (.mclk_i(mclk_i), .go_i(go),
    .bits_i(8'h14), .can_rx_o(can_rx_i), .frame_active_o(frame_active_i),
    .bit_tick_o(bit_tick_i));
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (drop_frame_o === 1'b1)
      drops <= drops + 1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge mclk_i);
    reg_wr_i <= 0;
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge mclk_i);
    reg_rd_i <= 0;
    #1 got = reg_rdata_o;
  endtask : rd
  task automatic idle();
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : idle
  task automatic pulse_go();
    @(posedge mclk_i);
    go <= 1;
    @(posedge mclk_i);
    go <= 0;
  endtask : pulse_go
  task automatic go_mode(int m, int old);
    int i;
    @(posedge mclk_i);
    tx_pending_i <= 1;
    pulse_go();
    wr(CMC_CTRL_ADDR, 8'(m << 5));
    for (i = 0; i < 3; i++) begin
      rd(CMC_STAT_ADDR);
      chk("held", 8'(old << 5), got);
    end
    @(posedge mclk_i);
    tx_pending_i <= 0;
    for (i = 0; i < 80 && got !== 8'(m << 5); i++)
      rd(CMC_STAT_ADDR);
    chk("status", 8'(m << 5), got);
    idle();
    chk("outputs", exp_out[m], outv);
  endtask : go_mode
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(83));
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1;
    rd(CMC_STAT_ADDR);
    chk("reset status", 8'h80, got);
    chk("reset func", 8'h00, {6'h00, func_mode_o});
    chk("reset depth", 8'h08, {4'h0, fifo_depth_o});
    wr(CMC_RXB_ADDR, {6'h00, CMC_RXM_ERR});
    idle();
    chk("keep errored", 8'h01, {7'h00, keep_errored_o});
    rd(4'hF);
    chk("unmapped", 8'h00, got);
    $display("reset test done");
    sdfl = $urandom_range(18);
    wr(CMC_FUNC_ADDR, 8'(sdfl << 2) | 8'h01);
    wr(CMC_FUNC_ADDR, 8'h4D);
    wr(CMC_FUNC_ADDR, 8'(sdfl << 2) | 8'h03);
    rd(CMC_FUNC_ADDR);
    chk("func reg", 8'(sdfl << 2) | 8'h01, got);
    chk("sdfl", 8'(sdfl), {3'h0, data_byte_filter_length_o});
    wr(CMC_FUNC_ADDR, 8'(sdfl << 2) | 8'h02);
    for (k = 0; k <= 6; k++) begin
      wr(CMC_BSEL_ADDR, k < 6 ? 8'(($urandom << k + 1 | 1 << k) & 63) : 0);
      idle();
      chk("fifo depth", 8'(k + 2), {4'h0, fifo_depth_o});
    end
    $display("config test done");
    foreach (seq_q[i])
      go_mode(seq_q[i], i ? seq_q[i - 1] : 4);
    $display("mode test done");
    wr(CMC_WAKE_ADDR, 8'h02);
    pulse_go();
    for (k = 0; k < 80 && got !== 8'h00; k++)
      rd(CMC_STAT_ADDR);
    chk("woke mode", 8'h00, got);
    chk("drops", 8'h01, 8'(drops));
    chk("wake irq", 8'h01, {7'h00, wake_irq_o});
    wr(CMC_WAKE_ADDR, 8'h07);
    idle();
    chk("wake masked", 8'h00, {7'h00, wake_irq_o});
    wr(CMC_FUNC_ADDR, 8'h00);
    rd(CMC_FUNC_ADDR);
    chk("locked func", 8'(sdfl << 2) | 8'h02, got);
    @(posedge mclk_i);
    resetn_i <= 0;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1;
    idle();
    chk("func again", 8'h00, {6'h00, func_mode_o});
    $display("wake test done");
    tally_and_finish();
  end
endmodule : testbench
